// File: rtl/dapr_pkg.sv
// Package with register map, field layout and timing constants for the datapath align/power registers
package dapr_pkg;
    localparam logic [11:0] ADDR_DELAY      = 12'h047;
    localparam logic [11:0] ADDR_ALIGN      = 12'h050;
    localparam logic [11:0] ADDR_KEY_I_LO   = 12'h051;
    localparam logic [11:0] ADDR_KEY_I_HI   = 12'h052;
    localparam logic [11:0] ADDR_KEY_Q_LO   = 12'h053;
    localparam logic [11:0] ADDR_KEY_Q_HI   = 12'h054;
    localparam logic [11:0] ADDR_LIMIT_LO   = 12'h060;
    localparam logic [11:0] ADDR_LIMIT_HI   = 12'h061;
    localparam logic [11:0] ADDR_AVG_CFG    = 12'h062;
    localparam logic [11:0] ADDR_POWER_LO   = 12'h063;
    localparam logic [11:0] ADDR_POWER_HI   = 12'h064;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h070;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h071;
    localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h072;
    localparam int          ADDR_SHIFT      = 2;
    localparam int          BIT_ARM         = 7;
    localparam int          BIT_KEY_HIT     = 5;
    localparam int          BIT_DONE_OK     = 4;
    localparam int          BIT_ERROR       = 3;
    localparam int          BIT_AVG_ON      = 7;
    localparam int          DELAY_LSB       = 1;
    localparam int          POWER_W         = 13;
    localparam int          LEN_MAX         = 10;
    localparam int          LEN_BASE        = 9;
    localparam int          MSB_BITS        = 6;
    localparam int          IRQ_W           = 3;
    localparam int          IRQ_ALIGN_OK    = 0;
    localparam int          IRQ_ALIGN_ERR   = 1;
    localparam int          IRQ_POWER       = 2;
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [1:0]  MODE_OFF        = 2'b00;
    localparam logic [1:0]  MODE_KEY        = 2'b10;
    localparam logic [1:0]  MODE_SYSREF     = 2'b01;
    typedef enum logic [1:0] {DAPR_IDLE, DAPR_ARMED, DAPR_DONE} dapr_align_e;
endpackage

// File: rtl/dapr_align.sv
// Oscillator phase alignment sequencer
`timescale 1ns/100ps
`default_nettype none
module dapr_align
    import dapr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        arm_rise,
    input  wire logic [1:0]  source_sel,
    input  wire logic [15:0] key_i,
    input  wire logic [15:0] key_q,
    input  wire logic        sample_valid,
    input  wire logic [15:0] sample_i,
    input  wire logic [15:0] sample_q,
    input  wire logic        sysref_edge,
    input  wire logic        rotating,
    output logic             phase_reset,
    output logic             key_hit,
    output logic             done_ok,
    output logic             align_error
);
    dapr_align_e state;
    logic        hit;

    always_comb begin
        hit = 1'b0;
        if (source_sel == MODE_KEY) begin
            hit = sample_valid && sample_i == key_i && sample_q == key_q;
        end else if (source_sel == MODE_SYSREF) begin
            hit = sysref_edge;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= DAPR_IDLE;
            phase_reset <= 1'b0;
            key_hit     <= 1'b0;
            done_ok     <= 1'b0;
            align_error <= 1'b0;
        end else if (ce) begin
            phase_reset <= 1'b0;
            if (arm_rise && source_sel != MODE_OFF) begin
                state       <= DAPR_ARMED;
                key_hit     <= 1'b0;
                done_ok     <= 1'b0;
                align_error <= 1'b0;
            end else begin
                case (state)
                    DAPR_ARMED: begin
                        if (source_sel == MODE_OFF) begin
                            state <= DAPR_IDLE;
                        end else if (hit) begin
                            state       <= DAPR_DONE;
                            phase_reset <= 1'b1;
                            done_ok     <= 1'b1;
                            key_hit     <= source_sel == MODE_KEY;
                            align_error <= rotating;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/dapr_power.sv
// Block average power detector (accumulator cleared after each window) with threshold protection
`timescale 1ns/100ps
`default_nettype none
module dapr_power
    import dapr_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               ce,
    input  wire logic               enable,
    input  wire logic [3:0]         length,
    input  wire logic [POWER_W-1:0] limit,
    input  wire logic               sample_valid,
    input  wire logic [15:0]        sample_i,
    input  wire logic [15:0]        sample_q,
    output logic [POWER_W-1:0]      average,
    output logic                    over_limit
);
    logic [20:0]        count;
    logic [32:0]        acc;
    logic [3:0]         len_eff;
    logic [MSB_BITS-1:0] mi;
    logic [MSB_BITS-1:0] mq;
    logic [POWER_W-1:0] sq;
    logic [POWER_W-1:0] next_average;

    function automatic logic [POWER_W-1:0] square(input logic [MSB_BITS-1:0] v);
        logic signed [MSB_BITS-1:0] s;
        logic [MSB_BITS-1:0]        m;
        s = v;
        m = s[MSB_BITS-1] ? MSB_BITS'(-s) : v;
        return POWER_W'(m) * POWER_W'(m);
    endfunction

    assign len_eff = (length > 4'(LEN_MAX)) ? 4'(LEN_MAX) : length;
    assign mi = sample_i[15 -: MSB_BITS];
    assign mq = sample_q[15 -: MSB_BITS];
    assign sq = square(mi) + square(mq);
    assign next_average = POWER_W'((acc + 33'(sq)) >> (LEN_BASE + 32'(len_eff)));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count      <= '0;
            acc        <= '0;
            average    <= '0;
            over_limit <= 1'b0;
        end else if (ce) begin
            if (!enable) begin
                count <= '0;
                acc   <= '0;
            end else if (sample_valid) begin
                if (count == 21'((1 << (LEN_BASE + 32'(len_eff))) - 1)) begin
                    count <= '0;
                    acc   <= '0;
                    if (!over_limit) begin
                        average <= next_average;
                    end
                    if (next_average > limit) begin
                        over_limit <= 1'b1;
                    end
                end else begin
                    count <= count + 21'd1;
                    acc   <= acc + 33'(sq);
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/dapr_regs.sv
// APB register bank for coarse delay, phase alignment and power detection
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module dapr_regs
    import dapr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sample_valid,
    input  wire logic [15:0] sample_i,
    input  wire logic [15:0] sample_q,
    input  wire logic        sysref_edge,
    input  wire logic        rotating,
    output logic [3:0]       q_channel_delay_step,
    output logic             phase_reset,
    output logic             power_over_limit_flag,
    output logic             irq
);
    logic [11:0]        idx;
    logic               wr;
    logic               rd_hit;
    logic               arm;
    logic               arm_d;
    logic [1:0]         phase_align_source_sel;
    logic [15:0]        i_sample_match_key;
    logic [15:0]        q_sample_match_key;
    logic [POWER_W-1:0] power_limit_value;
    logic               power_average_on;
    logic [3:0]         power_average_length;
    logic [POWER_W-1:0] power_average_readback;
    logic               phase_align_key_hit;
    logic               phase_align_done_ok;
    logic               phase_align_error;
    logic [IRQ_W-1:0]   irq_status;
    logic [IRQ_W-1:0]   irq_enable;
    logic [IRQ_W-1:0]   events;
    logic [IRQ_W-1:0]   clr;
    logic               ok_d;
    logic               err_d;
    logic               pwr_d;
    logic [7:0]         rd_byte;

    function automatic logic is_reg(input logic [11:0] a, input logic [11:0] r);
        return a == r;
    endfunction

    assign idx     = paddr[13:ADDR_SHIFT];
    assign wr      = psel && penable && pwrite && ce;
    assign pready  = 1'b1;

    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (is_reg(idx, ADDR_DELAY)) begin
            rd_byte = {4'h0, q_channel_delay_step[3:1], 1'b0};
        end else if (is_reg(idx, ADDR_ALIGN)) begin
            rd_byte = {arm, 1'b0, phase_align_key_hit, phase_align_done_ok, phase_align_error,
                       1'b0, phase_align_source_sel};
        end else if (is_reg(idx, ADDR_KEY_I_LO)) begin
            rd_byte = i_sample_match_key[7:0];
        end else if (is_reg(idx, ADDR_KEY_I_HI)) begin
            rd_byte = i_sample_match_key[15:8];
        end else if (is_reg(idx, ADDR_KEY_Q_LO)) begin
            rd_byte = q_sample_match_key[7:0];
        end else if (is_reg(idx, ADDR_KEY_Q_HI)) begin
            rd_byte = q_sample_match_key[15:8];
        end else if (is_reg(idx, ADDR_LIMIT_LO)) begin
            rd_byte = power_limit_value[7:0];
        end else if (is_reg(idx, ADDR_LIMIT_HI)) begin
            rd_byte = {3'h0, power_limit_value[12:8]};
        end else if (is_reg(idx, ADDR_AVG_CFG)) begin
            rd_byte = {power_average_on, 3'h0, power_average_length};
        end else if (is_reg(idx, ADDR_POWER_LO)) begin
            rd_byte = power_average_readback[7:0];
        end else if (is_reg(idx, ADDR_POWER_HI)) begin
            rd_byte = {3'h0, power_average_readback[12:8]};
        end else if (is_reg(idx, ADDR_IRQ_STATUS)) begin
            rd_byte = {5'h0, irq_status};
        end else if (is_reg(idx, ADDR_IRQ_ENABLE)) begin
            rd_byte = {5'h0, irq_enable};
        end else if (is_reg(idx, ADDR_IRQ_CLEAR)) begin
            rd_byte = 8'h00;
        end else begin
            rd_hit = 1'b0;
        end
    end

    assign pslverr = psel && penable && !rd_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // Coarse delay: code scales to half-period steps from -4 periods
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_channel_delay_step <= 4'h0;
        end else if (wr && is_reg(idx, ADDR_DELAY)) begin
            q_channel_delay_step <= {1'b0, pwdata[DELAY_LSB +: 3]} << 1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm                    <= 1'b0;
            arm_d                  <= 1'b0;
            phase_align_source_sel <= MODE_OFF;
        end else if (ce) begin
            arm_d <= arm;
            if (wr && is_reg(idx, ADDR_ALIGN)) begin
                arm                    <= pwdata[BIT_ARM];
                phase_align_source_sel <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            i_sample_match_key <= {RST_BYTE, RST_BYTE};
            q_sample_match_key <= {RST_BYTE, RST_BYTE};
        end else if (wr) begin
            if (is_reg(idx, ADDR_KEY_I_LO)) begin
                i_sample_match_key[7:0] <= pwdata[7:0];
            end else if (is_reg(idx, ADDR_KEY_I_HI)) begin
                i_sample_match_key[15:8] <= pwdata[7:0];
            end else if (is_reg(idx, ADDR_KEY_Q_LO)) begin
                q_sample_match_key[7:0] <= pwdata[7:0];
            end else if (is_reg(idx, ADDR_KEY_Q_HI)) begin
                q_sample_match_key[15:8] <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_limit_value    <= '0;
            power_average_on     <= 1'b0;
            power_average_length <= 4'h0;
        end else if (wr) begin
            if (is_reg(idx, ADDR_LIMIT_LO)) begin
                power_limit_value[7:0] <= pwdata[7:0];
            end else if (is_reg(idx, ADDR_LIMIT_HI)) begin
                power_limit_value[12:8] <= pwdata[4:0];
            end else if (is_reg(idx, ADDR_AVG_CFG)) begin
                power_average_on     <= pwdata[BIT_AVG_ON];
                power_average_length <= pwdata[3:0];
            end
        end
    end

    dapr_align u_align (
        .pclk         (pclk),
        .presetn      (presetn),
        .ce           (ce),
        .arm_rise     (arm && !arm_d),
        .source_sel   (phase_align_source_sel),
        .key_i        (i_sample_match_key),
        .key_q        (q_sample_match_key),
        .sample_valid (sample_valid),
        .sample_i     (sample_i),
        .sample_q     (sample_q),
        .sysref_edge  (sysref_edge),
        .rotating     (rotating),
        .phase_reset  (phase_reset),
        .key_hit      (phase_align_key_hit),
        .done_ok      (phase_align_done_ok),
        .align_error  (phase_align_error)
    );

    dapr_power u_power (
        .pclk         (pclk),
        .presetn      (presetn),
        .ce           (ce),
        .enable       (power_average_on),
        .length       (power_average_length),
        .limit        (power_limit_value),
        .sample_valid (sample_valid),
        .sample_i     (sample_i),
        .sample_q     (sample_q),
        .average      (power_average_readback),
        .over_limit   (power_over_limit_flag)
    );

    // Interrupt events on rising status
    assign events[IRQ_ALIGN_OK]  = phase_align_done_ok && !ok_d;
    assign events[IRQ_ALIGN_ERR] = phase_align_error && !err_d;
    assign events[IRQ_POWER]     = power_over_limit_flag && !pwr_d;
    assign clr = (wr && is_reg(idx, ADDR_IRQ_CLEAR)) ? pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ok_d       <= 1'b0;
            err_d      <= 1'b0;
            pwr_d      <= 1'b0;
            irq_status <= '0;
            irq_enable <= '0;
        end else if (ce) begin
            ok_d       <= phase_align_done_ok;
            err_d      <= phase_align_error;
            pwr_d      <= power_over_limit_flag;
            irq_status <= (irq_status & ~clr) | events;
            if (wr && is_reg(idx, ADDR_IRQ_ENABLE)) begin
                irq_enable <= pwdata[IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_status & irq_enable);
endmodule
`default_nettype wire

// File: test/dapr_regs_sva.sv
// Port checker for the datapath align/power register bank
`timescale 1ns/100ps
`default_nettype none
module dapr_regs_sva
    import dapr_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sample_valid,
    input wire logic [15:0] sample_i,
    input wire logic [15:0] sample_q,
    input wire logic        sysref_edge,
    input wire logic        rotating,
    input wire logic [3:0]  q_channel_delay_step,
    input wire logic        phase_reset,
    input wire logic        power_over_limit_flag,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic dly_wr;
    assign dly_wr = psel && penable && pwrite && ce && (paddr == {ADDR_DELAY, 2'b00});
    property p_zero_wait; psel && penable |-> pready; endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("access not answered at once");
    property p_err_phase; pslverr |-> psel && penable; endproperty
    a_err_phase: assert property (p_err_phase) else $error("error outside access phase");
    property p_err_data; psel && penable && !pwrite && pslverr |-> prdata == 32'h0; endproperty
    a_err_data: assert property (p_err_data) else $error("refused read returned data");
    property p_dly_load; dly_wr |=> q_channel_delay_step == {$past(pwdata[3:1]), 1'b0}; endproperty
    a_dly_load: assert property (p_dly_load) else $error("delay code not loaded");
    property p_dly_hold; !dly_wr |=> $stable(q_channel_delay_step); endproperty
    a_dly_hold: assert property (p_dly_hold) else $error("delay code moved unasked");
    property p_dly_half; q_channel_delay_step[0] == 1'b0; endproperty
    a_dly_half: assert property (p_dly_half) else $error("delay step not whole");
    property p_pulse; phase_reset |=> !phase_reset; endproperty
    a_pulse: assert property (p_pulse) else $error("phase reset longer than one cycle");
    property p_cause; phase_reset |-> $past(sample_valid) || $past(sysref_edge); endproperty
    a_cause: assert property (p_cause) else $error("phase reset without event");
    property p_sticky; power_over_limit_flag |=> power_over_limit_flag; endproperty
    a_sticky: assert property (p_sticky) else $error("power flag dropped");
endmodule
`default_nettype wire

// File: test/dapr_regs_tb_top.sv
// Self-checking bench for the datapath align/power register bank
`timescale 1ns/100ps
`default_nettype none
module dapr_regs_tb_top
    import dapr_pkg::*;
;
    logic        pclk, presetn, ce, psel, penable, pwrite, sample_valid, sysref_edge, rotating;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, phase_reset, power_over_limit_flag, irq;
    logic [3:0]  q_channel_delay_step;
    logic [15:0] sample_i, sample_q;
    logic [31:0] exp_q[$], msk_q[$];
    logic        err_q[$];
    logic [11:0] tbl[11];
    logic [7:0]  v;
    int          bad_count, num_checks, pulses, seed;

    dapr_regs DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .sample_i(sample_i), .sample_q(sample_q),
        .sysref_edge(sysref_edge), .rotating(rotating), .q_channel_delay_step(q_channel_delay_step),
        .phase_reset(phase_reset), .power_over_limit_flag(power_over_limit_flag), .irq(irq));

    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] off, input logic [31:0] d);
        int n;
        if (psel) begin
            @(posedge pclk);
        end
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {off, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            print_verdict();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] off, input logic [31:0] d);
        apb(1'b1, off, d);
    endtask
    task rd(input logic [11:0] off, input logic [31:0] e, input logic [31:0] m, input logic er);
        exp_q.push_back(e);
        msk_q.push_back(m);
        err_q.push_back(er);
        apb(1'b0, off, 32'h0);
    endtask
    task feed(input int n, input logic [15:0] vi, input logic [15:0] vq, input logic rnd);
        repeat (n) begin
            sample_valid <= 1'b1;
            sample_i     <= rnd ? {6'b011111, 10'($urandom)} : vi;
            sample_q     <= rnd ? {6'b011111, 10'($urandom)} : vq;
            @(posedge pclk);
        end
        sample_valid <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask

    // Read results taken off the queue as they complete
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0, "read without note");
            end else begin
                chk(prdata & msk_q.pop_front(), exp_q.pop_front(), "read data");
                chk(32'(pslverr), 32'(err_q.pop_front()), "slave error");
            end
        end
        if (phase_reset === 1'b1) begin
            pulses++;
        end
    end

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, sample_valid, sysref_edge, rotating} = 6'h00;
        paddr = 14'h0000;
        pwdata = 32'h0;
        {sample_i, sample_q} = 32'h0;
        tbl = '{ADDR_ALIGN, ADDR_KEY_I_LO, ADDR_KEY_I_HI, ADDR_KEY_Q_LO, ADDR_KEY_Q_HI, ADDR_LIMIT_LO,
                ADDR_LIMIT_HI, ADDR_AVG_CFG, ADDR_POWER_LO, ADDR_POWER_HI, ADDR_IRQ_STATUS};
        seed = $urandom(32'hF1A823BC);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (tbl[k]) rd(tbl[k], 32'h0, 32'hFF, 1'b0);
        for (int k = 1; k <= 5; k++) begin
            v = 8'($urandom);
            wr(tbl[k], {24'h0, v});
            rd(tbl[k], {24'h0, v}, 32'hFF, 1'b0);
        end
        // Write with clock enable low must be ignored
        ce <= 1'b0;
        wr(ADDR_LIMIT_LO, {24'h0, ~v});
        ce <= 1'b1;
        rd(ADDR_LIMIT_LO, {24'h0, v}, 32'hFF, 1'b0);
        wr(ADDR_LIMIT_HI, 32'hFF);
        rd(ADDR_LIMIT_HI, 32'h1F, 32'hFF, 1'b0);
        wr(ADDR_AVG_CFG, 32'hFA);
        rd(ADDR_AVG_CFG, 32'h8A, 32'hFF, 1'b0);
        wr(ADDR_AVG_CFG, 32'h00);
        rd(12'h055, 32'h0, 32'hFFFFFFFF, 1'b1);
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_DELAY, 32'(c << 1));
            @(posedge pclk);
            chk(32'(q_channel_delay_step), 32'(c * 2), "delay step");
            rd(ADDR_DELAY, 32'(c << 1), 32'hFF, 1'b0);
        end
        $display("test delay done");
        wr(ADDR_IRQ_ENABLE, 32'h7);
        wr(ADDR_KEY_I_LO, 32'h34);
        wr(ADDR_KEY_I_HI, 32'h12);
        wr(ADDR_KEY_Q_LO, 32'hCD);
        wr(ADDR_KEY_Q_HI, 32'hAB);
        wr(ADDR_ALIGN, 32'h02);
        wr(ADDR_ALIGN, 32'h82);
        rd(ADDR_ALIGN, 32'h82, 32'hBB, 1'b0);
        feed(1, 16'h1234, 16'h0000, 1'b0);
        feed(1, 16'h0000, 16'hABCD, 1'b0);
        chk(pulses, 0, "no phase reset on half match");
        feed(1, 16'h1234, 16'hABCD, 1'b0);
        chk(pulses, 1, "phase reset on key match");
        chk(32'(irq), 32'h1, "irq on align done");
        rd(ADDR_ALIGN, 32'hB2, 32'hBB, 1'b0);
        rd(ADDR_IRQ_STATUS, 32'h1, 32'h7, 1'b0);
        wr(ADDR_ALIGN, 32'h82);
        feed(1, 16'h1234, 16'hABCD, 1'b0);
        chk(pulses, 1, "static arm level");
        wr(ADDR_IRQ_ENABLE, 32'h0);
        @(posedge pclk);
        chk(32'(irq), 32'h0, "irq masked");
        wr(ADDR_IRQ_CLEAR, 32'h7);
        rd(ADDR_IRQ_STATUS, 32'h0, 32'h7, 1'b0);
        wr(ADDR_IRQ_ENABLE, 32'h7);
        wr(ADDR_ALIGN, 32'h00);
        wr(ADDR_ALIGN, 32'h80);
        sysref_edge <= 1'b1;
        @(posedge pclk);
        sysref_edge <= 1'b0;
        feed(1, 16'h1234, 16'hABCD, 1'b0);
        chk(pulses, 1, "mode off stays idle");
        wr(ADDR_ALIGN, 32'h01);
        rotating <= 1'b1;
        wr(ADDR_ALIGN, 32'h81);
        @(posedge pclk);
        sysref_edge <= 1'b1;
        @(posedge pclk);
        sysref_edge <= 1'b0;
        feed(0, 16'h0, 16'h0, 1'b0);
        chk(pulses, 2, "phase reset on sysref");
        rd(ADDR_ALIGN, 32'h99, 32'hBB, 1'b0);
        rd(ADDR_IRQ_STATUS, 32'h3, 32'h7, 1'b0);
        rotating <= 1'b0;
        wr(ADDR_IRQ_CLEAR, 32'h7);
        $display("test alignment done");
        wr(ADDR_LIMIT_LO, 32'hFF);
        wr(ADDR_LIMIT_HI, 32'h1F);
        wr(ADDR_AVG_CFG, 32'h80);
        feed(512, 16'h0, 16'h0, 1'b1);
        rd(ADDR_POWER_LO, 32'h82, 32'hFF, 1'b0);
        rd(ADDR_POWER_HI, 32'h07, 32'hFF, 1'b0);
        wr(ADDR_AVG_CFG, 32'h00);
        feed(512, 16'h0, 16'h0, 1'b0);
        rd(ADDR_POWER_LO, 32'h82, 32'hFF, 1'b0);
        wr(ADDR_AVG_CFG, 32'h80);
        feed(512, 16'h0, 16'h0, 1'b0);
        rd(ADDR_POWER_LO, 32'h00, 32'hFF, 1'b0);
        wr(ADDR_LIMIT_LO, 32'hE8);
        wr(ADDR_LIMIT_HI, 32'h03);
        wr(ADDR_AVG_CFG, 32'h81);
        feed(512, 16'h0, 16'h0, 1'b1);
        chk(32'(power_over_limit_flag), 32'h0, "flag before full window");
        feed(512, 16'h0, 16'h0, 1'b1);
        chk(32'(power_over_limit_flag), 32'h1, "flag over limit");
        chk(32'(irq), 32'h1, "irq on power flag");
        rd(ADDR_IRQ_STATUS, 32'h4, 32'h7, 1'b0);
        $display("test power done");
        print_verdict();
    end
endmodule

bind dapr_regs dapr_regs_sva u_sva (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .sample_i(sample_i),
    .sample_q(sample_q), .sysref_edge(sysref_edge), .rotating(rotating),
    .q_channel_delay_step(q_channel_delay_step), .phase_reset(phase_reset),
    .power_over_limit_flag(power_over_limit_flag), .irq(irq));
`default_nettype wire
